// [wwd_pkg.sv]
// Package: register map, field layout and carrier types of the watchdog
package wwd_pkg;

   // Register byte offsets
   localparam logic [7:0] WWD_CFG_OFS = 8'h00;
   localparam logic [7:0] WWD_RC_OFS = 8'h04;

   // Configuration word fields
   localparam int WWD_PS_LSB = 0;
   localparam int WWD_PS_W = 4;
   localparam int WWD_PRESC_BIT = 4;
   localparam int WWD_MODE_LSB = 5;
   localparam int WWD_WIN_OFF_BIT = 7;
   localparam int WWD_CSEL_LSB = 8;
   localparam int WWD_CFG_W = 10;
   localparam logic [15:0] WWD_CFG_RESET = 16'h00ff;

   // Reset control fields
   localparam int WWD_RC_IDLE_BIT = 2;
   localparam int WWD_RC_SLEEP_BIT = 3;
   localparam int WWD_RC_FLAG_BIT = 4;
   localparam int WWD_RC_SWEN_BIT = 5;

   // Divider figures
   localparam int WWD_PRESC_SHORT = 32;
   localparam int WWD_PRESC_LONG = 128;
   localparam int WWD_CNT_W = 22;

   // Enable mode codes
   localparam logic [1:0] WWD_MODE_OFF = 2'h0;
   localparam logic [1:0] WWD_MODE_ACTIVE = 2'h1;
   localparam logic [1:0] WWD_MODE_SOFT = 2'h2;
   localparam logic [1:0] WWD_MODE_ON = 2'h3;

   // Clock source codes
   localparam logic [1:0] WWD_SRC_RC = 2'h0;
   localparam logic [1:0] WWD_SRC_SEC = 2'h1;
   localparam logic [1:0] WWD_SRC_SYST = 2'h2;

   typedef enum logic [2:0] {
      WWD_RUN = 3'b001,
      WWD_SLEEP = 3'b010,
      WWD_IDLE = 3'b100
   } wwd_pwr_e;

   // Events from the processor core
   typedef struct packed {
      logic clear_watchdog_instr;
      logic power_save_instr;
      logic power_save_idle;
      logic wake_other;
      logic clock_switch_done;
   } wwd_core_s;

   // Watchdog clock ticks
   typedef struct packed {
      logic low_power_rc_clock;
      logic secondary_oscillator;
      logic system_timer;
   } wwd_ticks_s;

endpackage

// [wwd_divider.sv]
// Combined prescaler and postscaler counter with window detection
`timescale 1ns/1ps
module wwd_divider
   import wwd_pkg::*;
#(
   parameter int CNT_W = WWD_CNT_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Control
   input wire logic tick,
   input wire logic clear,
   input wire logic prescale_select,
   input wire logic [WWD_PS_W-1:0] postscale_select,
   // Status
   output logic expire,
   output logic window_open,
   output logic [CNT_W-1:0] count
);

   localparam int PER_W = CNT_W + 1;

   if (CNT_W < WWD_CNT_W) begin : g_cnt_check
      $error("wwd_divider: CNT_W too small for 1:128 x 1:32768");
   end

   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   wire [PER_W-1:0] presc_w;
   wire [PER_W-1:0] period_w;
   wire [PER_W-1:0] terminal_w;
   wire [PER_W-1:0] win_start_w;
   wire [PER_W-1:0] count_ext_w;

   // Period is prescale times two to the n
   assign presc_w = prescale_select ? PER_W'(WWD_PRESC_LONG) : PER_W'(WWD_PRESC_SHORT);
   assign period_w = presc_w << postscale_select;
   assign terminal_w = period_w - PER_W'(1);
   assign win_start_w = period_w - (period_w >> 2);
   assign count_ext_w = {1'b0, count_q};
   assign expire = tick && (count_ext_w == terminal_w);
   assign window_open = count_ext_w >= win_start_w;
   assign count = count_q;

   always_comb begin
      count_d = count_q;
      if (clear) begin
         count_d = '0;
      end else if (expire) begin
         count_d = '0;
      end else if (tick) begin
         count_d = count_q + CNT_W'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         count_q <= '0;
      end else begin
         count_q <= count_d;
      end
   end

endmodule

// [wwd_watchdog.sv]
// Windowed watchdog timer with power-save handling and register port
`timescale 1ns/1ps
module wwd_watchdog
   import wwd_pkg::*;
#(
   parameter int CNT_W = WWD_CNT_W
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   // Core events and clock ticks
   input wwd_core_s core_evt,
   input wwd_ticks_s src_tick,
   // Clock source enables
   output logic low_power_rc_clock_enable,
   output logic secondary_oscillator_enable,
   output logic systimer_enable,
   // Core side results
   output logic watchdog_reset,
   output logic wake_core,
   output logic in_sleep,
   output logic in_idle
);

   if (CNT_W < WWD_CNT_W) begin : g_cnt_check
      $error("wwd_watchdog: CNT_W too small");
   end

   // State
   wwd_pwr_e state_q;
   wwd_pwr_e state_d;
   logic [WWD_CFG_W-1:0] cfg_q;
   logic [WWD_CFG_W-1:0] cfg_d;
   logic sw_en_q;
   logic sw_en_d;
   logic flag_q;
   logic flag_d;
   logic sleep_bit_q;
   logic sleep_bit_d;
   logic idle_bit_q;
   logic idle_bit_d;
   logic [15:0] rdata_q;
   logic wdt_reset_q;
   logic wake_q;
   logic rc_en_q;
   logic sec_en_q;
   logic syst_en_q;

   // Configuration fields
   wire [WWD_PS_W-1:0] postscale_select;
   wire prescale_select;
   wire [1:0] watchdog_enable_mode;
   wire window_disable;
   wire [1:0] clock_select;
   assign postscale_select = cfg_q[WWD_PS_LSB +: WWD_PS_W];
   assign prescale_select = cfg_q[WWD_PRESC_BIT];
   assign watchdog_enable_mode = cfg_q[WWD_MODE_LSB +: 2];
   assign window_disable = cfg_q[WWD_WIN_OFF_BIT];
   assign clock_select = cfg_q[WWD_CSEL_LSB +: 2];

   // Power state decode
   wire run_w;
   wire asleep_w;
   wire saving_w;
   assign run_w = (state_q == WWD_RUN);
   assign asleep_w = (state_q == WWD_SLEEP);
   assign saving_w = !run_w;

   // Enable decode
   wire enabled_w;
   assign enabled_w = (watchdog_enable_mode == WWD_MODE_ON) ||
                      ((watchdog_enable_mode == WWD_MODE_SOFT) && sw_en_q) ||
                      ((watchdog_enable_mode == WWD_MODE_ACTIVE) && !asleep_w);

   // Clock source selection
   wire use_rc_w;
   wire use_sec_w;
   wire use_syst_w;
   wire sel_tick_w;
   wire count_tick_w;
   assign use_rc_w = asleep_w || (clock_select == WWD_SRC_RC) ||
                     (clock_select == 2'h3);
   assign use_sec_w = !asleep_w && (clock_select == WWD_SRC_SEC);
   assign use_syst_w = !asleep_w && (clock_select == WWD_SRC_SYST);
   assign sel_tick_w = (use_rc_w && src_tick.low_power_rc_clock) ||
                       (use_sec_w && src_tick.secondary_oscillator) ||
                       (use_syst_w && src_tick.system_timer);
   assign count_tick_w = enabled_w && sel_tick_w;

   // Divider
   wire expire_w;
   wire window_open_w;
   wire [CNT_W-1:0] count_w;
   wire div_clear_w;

   wwd_divider #(
      .CNT_W(CNT_W)
   ) u_divider (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .tick(count_tick_w),
      .clear(div_clear_w),
      .prescale_select(prescale_select),
      .postscale_select(postscale_select),
      .expire(expire_w),
      .window_open(window_open_w),
      .count(count_w)
   );

   // Event decode
   wire clr_cmd_w;
   wire early_clear_w;
   wire good_clear_w;
   wire wdt_trip_w;
   wire enter_ps_w;
   wire exit_ps_w;
   wire wake_wdt_w;
   assign clr_cmd_w = run_w && core_evt.clear_watchdog_instr && enabled_w;
   assign early_clear_w = clr_cmd_w && !window_disable && !window_open_w;
   assign good_clear_w = clr_cmd_w && (window_disable || window_open_w);
   assign wdt_trip_w = run_w && (expire_w || early_clear_w);
   assign enter_ps_w = run_w && core_evt.power_save_instr && !wdt_trip_w;
   assign wake_wdt_w = saving_w && expire_w;
   assign exit_ps_w = saving_w && (expire_w || core_evt.wake_other);
   assign div_clear_w = wdt_trip_w || good_clear_w || enter_ps_w || exit_ps_w ||
                        core_evt.clock_switch_done;

   // Register decode
   wire cfg_sel_w;
   wire rc_sel_w;
   wire rc_wr_w;
   wire [15:0] rc_view_w;
   wire [15:0] rd_mux_w;
   assign cfg_sel_w = (reg_addr == WWD_CFG_OFS);
   assign rc_sel_w = (reg_addr == WWD_RC_OFS);
   assign rc_wr_w = reg_write && rc_sel_w;
   assign rc_view_w = (16'(sw_en_q) << WWD_RC_SWEN_BIT) | (16'(flag_q) << WWD_RC_FLAG_BIT) |
                      (16'(sleep_bit_q) << WWD_RC_SLEEP_BIT) |
                      (16'(idle_bit_q) << WWD_RC_IDLE_BIT);
   assign rd_mux_w = !reg_read ? 16'h0000 :
                     cfg_sel_w ? 16'(cfg_q) :
                     rc_sel_w ? rc_view_w : 16'h0000;

   // Next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         WWD_RUN: begin
            if (enter_ps_w) begin
               state_d = core_evt.power_save_idle ? WWD_IDLE : WWD_SLEEP;
            end
         end
         WWD_SLEEP, WWD_IDLE: begin
            if (exit_ps_w) begin
               state_d = WWD_RUN;
            end
         end
      endcase
   end

   // Register next values, hardware set or clear wins over software write
   always_comb begin
      cfg_d = cfg_q;
      if (reg_write && cfg_sel_w) begin
         cfg_d = reg_wdata[WWD_CFG_W-1:0];
      end
      sw_en_d = rc_wr_w ? reg_wdata[WWD_RC_SWEN_BIT] : sw_en_q;
      if (wdt_trip_w) begin
         sw_en_d = 1'b0;
      end
      flag_d = rc_wr_w ? reg_wdata[WWD_RC_FLAG_BIT] : flag_q;
      if (wdt_trip_w || wake_wdt_w) begin
         flag_d = 1'b1;
      end
      sleep_bit_d = rc_wr_w ? reg_wdata[WWD_RC_SLEEP_BIT] : sleep_bit_q;
      idle_bit_d = rc_wr_w ? reg_wdata[WWD_RC_IDLE_BIT] : idle_bit_q;
      if (enter_ps_w && !core_evt.power_save_idle) begin
         sleep_bit_d = 1'b1;
      end
      if (enter_ps_w && core_evt.power_save_idle) begin
         idle_bit_d = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= WWD_RUN;
         cfg_q <= WWD_CFG_RESET[WWD_CFG_W-1:0];
         sw_en_q <= 1'b0;
         flag_q <= 1'b0;
         sleep_bit_q <= 1'b0;
         idle_bit_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cfg_q <= cfg_d;
         sw_en_q <= sw_en_d;
         flag_q <= flag_d;
         sleep_bit_q <= sleep_bit_d;
         idle_bit_q <= idle_bit_d;
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 16'h0000;
         wdt_reset_q <= 1'b0;
         wake_q <= 1'b0;
         rc_en_q <= 1'b0;
         sec_en_q <= 1'b0;
         syst_en_q <= 1'b0;
      end else begin
         rdata_q <= rd_mux_w;
         wdt_reset_q <= wdt_trip_w;
         wake_q <= wake_wdt_w;
         rc_en_q <= enabled_w && use_rc_w;
         sec_en_q <= enabled_w && use_sec_w;
         syst_en_q <= enabled_w && use_syst_w;
      end
   end

   assign reg_rdata = rdata_q;
   assign watchdog_reset = wdt_reset_q;
   assign wake_core = wake_q;
   assign in_sleep = state_q[1];
   assign in_idle = state_q[2];
   assign low_power_rc_clock_enable = rc_en_q;
   assign secondary_oscillator_enable = sec_en_q;
   assign systimer_enable = syst_en_q;

   // Checks
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   property p_trip_flag;
      wdt_trip_w |=> flag_q && watchdog_reset && !sw_en_q;
   endproperty
   a_trip_flag: assert property (p_trip_flag) else $error("trip without reset or flag");

   property p_flag_set_wins;
      (rc_wr_w && !reg_wdata[WWD_RC_FLAG_BIT] && (wdt_trip_w || wake_wdt_w)) |=> flag_q;
   endproperty
   a_flag_set_wins: assert property (p_flag_set_wins) else $error("flag lost to clear");

   property p_sleep_wake;
      (saving_w && expire_w) |=> wake_core && run_w && !watchdog_reset && count_w == '0;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("no wake on timeout");

   property p_early_clear;
      (clr_cmd_w && !window_disable && !window_open_w) |=> watchdog_reset;
   endproperty
   a_early_clear: assert property (p_early_clear) else $error("early clear not punished");

   property p_good_clear;
      (clr_cmd_w && window_disable && !expire_w) |=> !watchdog_reset && count_w == '0;
   endproperty
   a_good_clear: assert property (p_good_clear) else $error("clear did not restart");

   property p_enter_ps;
      enter_ps_w |=> !run_w && count_w == '0 && (in_sleep ? sleep_bit_q : idle_bit_q);
   endproperty
   a_enter_ps: assert property (p_enter_ps) else $error("power save entry wrong");

   property p_short_period;
      (expire_w && !prescale_select && postscale_select == 4'h0) |-> count_w == 22'h00_001f;
   endproperty
   a_short_period: assert property (p_short_period) else $error("1:32 period wrong");

   property p_long_period;
      (expire_w && prescale_select && postscale_select == 4'hf) |-> count_w == 22'h3f_ffff;
   endproperty
   a_long_period: assert property (p_long_period) else $error("longest period wrong");

   property p_off_holds;
      (watchdog_enable_mode == WWD_MODE_OFF && !div_clear_w) |=> $stable(count_w);
   endproperty
   a_off_holds: assert property (p_off_holds) else $error("disabled watchdog counts");

   property p_soft_gate;
      (watchdog_enable_mode == WWD_MODE_SOFT && !sw_en_q && !div_clear_w) |=> $stable(count_w);
   endproperty
   a_soft_gate: assert property (p_soft_gate) else $error("soft mode counts unset");

   property p_sleep_source;
      (enabled_w && asleep_w) |=> low_power_rc_clock_enable && !secondary_oscillator_enable &&
                                  !systimer_enable;
   endproperty
   a_sleep_source: assert property (p_sleep_source) else $error("sleep not on RC clock");

   c_run_timeout: cover property (run_w && expire_w);
   c_sleep_wake: cover property (asleep_w && expire_w);
   c_early_clear: cover property (early_clear_w);
   c_window_clear: cover property (clr_cmd_w && !window_disable && window_open_w);

endmodule

// [wwd_core_model.sv]
// Core model: issues instructions and supplies source ticks
`timescale 1ns/1ps
module wwd_core_model
   import wwd_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // Source enables
   input wire logic low_power_rc_clock_enable,
   input wire logic secondary_oscillator_enable,
   input wire logic systimer_enable,
   // Core events and ticks
   output wwd_core_s core_evt,
   output wwd_ticks_s src_tick
);
   wwd_core_s evt_q = '0;
   wwd_ticks_s ticks_q = '0;

   assign core_evt = evt_q;
   assign src_tick = ticks_q;

   // Only an enabled oscillator delivers ticks
   always @(posedge ref_clk) begin
      ticks_q <= arst_n ? {low_power_rc_clock_enable, secondary_oscillator_enable,
                           systimer_enable} : 3'h0;
   end

   // One-cycle instruction pulse
   task automatic issue(input wwd_core_s ev);
      @(posedge ref_clk);
      evt_q <= ev;
      @(posedge ref_clk);
      evt_q <= '0;
   endtask
endmodule

// [windowed_watchdog_timer_test.sv]
// Self-checking testbench of the windowed watchdog
`timescale 1ns/1ps
module windowed_watchdog_timer_test;
   import wwd_pkg::*;
   localparam wwd_core_s EV_CLR = 5'h10;
   localparam wwd_core_s EV_SLP = 5'h08;
   localparam wwd_core_s EV_IDL = 5'h0c;
   localparam wwd_core_s EV_WAKE = 5'h02;
   localparam wwd_core_s EV_CSW = 5'h01;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata;
   wwd_core_s core_evt;
   wwd_ticks_s src_tick;
   logic low_power_rc_clock_enable, secondary_oscillator_enable, systimer_enable;
   logic watchdog_reset, wake_core, in_sleep, in_idle;
   int bad_count = 0;
   int samples_checked = 0;
   int rst_seen = 0;
   int wake_seen = 0;
   logic [31:0] seed = 32'h0678_2609;

   always #50 ref_clk = ~ref_clk;

   wwd_watchdog dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .core_evt(core_evt), .src_tick(src_tick),
      .low_power_rc_clock_enable(low_power_rc_clock_enable),
      .secondary_oscillator_enable(secondary_oscillator_enable),
      .systimer_enable(systimer_enable), .watchdog_reset(watchdog_reset),
      .wake_core(wake_core), .in_sleep(in_sleep), .in_idle(in_idle));

   wwd_core_model core_u (.ref_clk(ref_clk), .arst_n(arst_n),
      .low_power_rc_clock_enable(low_power_rc_clock_enable),
      .secondary_oscillator_enable(secondary_oscillator_enable),
      .systimer_enable(systimer_enable),
      .core_evt(core_evt), .src_tick(src_tick));

   // Pulse counters
   always @(posedge ref_clk) begin
      if (watchdog_reset === 1'b1) rst_seen++;
      if (wake_core === 1'b1) wake_seen++;
   end

   function automatic logic [31:0] rnd();
      seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
      return seed;
   endfunction

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask

   task automatic reg_rd(input logic [7:0] a, input logic [15:0] exp, input string name);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      #1;
      check(name, reg_rdata, exp);
   endtask

   // Cycles until the next pulse must lie in lo..hi
   task automatic wait_evt(input bit wk, input int lo, input int hi, input string name);
      int c0;
      int n;
      #1;
      c0 = wk ? wake_seen : rst_seen;
      n = 0;
      while ((wk ? wake_seen : rst_seen) == c0 && n <= hi) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      check(name, 16'(n >= lo && n <= hi), 16'h0001);
   endtask

   task automatic no_evt(input bit wk, input int n, input string name);
      int c0;
      #1;
      c0 = wk ? wake_seen : rst_seen;
      repeat (n) @(posedge ref_clk);
      #1;
      check(name, 16'((wk ? wake_seen : rst_seen) - c0), 16'h0000);
   endtask

   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   initial begin
      #2_000_000;
      bad_count++;
      finish_test;
   end

   initial begin
      logic [31:0] r;
      int p;
      int n;
      logic psa;
      int c;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      reg_rd(WWD_CFG_OFS, WWD_CFG_RESET, "cfg_reset");
      reg_rd(WWD_RC_OFS, 16'h0000, "rc_reset");
      r = rnd();
      reg_wr(8'h08, r[15:0]);
      reg_rd(8'h08, 16'h0000, "unmapped");
      reg_rd(WWD_CFG_OFS, WWD_CFG_RESET, "cfg_kept");
      // Always on, window off, RC source, 1:32, 1:1
      reg_wr(WWD_CFG_OFS, 16'h00e0);
      core_u.issue(EV_CSW);
      #1;
      check("rc_en", {15'h0000, low_power_rc_clock_enable}, 16'h0001);
      check("sec_off", {15'h0000, secondary_oscillator_enable}, 16'h0000);
      wait_evt(0, 29, 35, "run_timeout");
      reg_rd(WWD_RC_OFS, 16'h0010, "flag_set");
      reg_wr(WWD_RC_OFS, 16'h0000);
      reg_rd(WWD_RC_OFS, 16'h0000, "flag_sw_clear");
      // Random and corner divider ratios
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         psa = (i == 7) ? 1'b1 : r[4];
         n = (i == 0) ? 0 : (i == 7) ? 4 : int'(r[1:0]);
         p = (psa ? WWD_PRESC_LONG : WWD_PRESC_SHORT) << n;
         reg_wr(WWD_CFG_OFS, 16'h00e0 | {11'h000, psa, 4'(n)});
         core_u.issue(EV_CSW);
         wait_evt(0, p - 3, p + 3, "ratio");
      end
      // Clear and clock switch restart the count
      reg_wr(WWD_CFG_OFS, 16'h00e0);
      core_u.issue(EV_CSW);
      repeat (3) begin
         no_evt(0, 20, "clr_hold");
         core_u.issue(EV_CLR);
      end
      repeat (2) begin
         no_evt(0, 20, "csw_hold");
         core_u.issue(EV_CSW);
      end
      wait_evt(0, 29, 35, "after_restart");
      reg_wr(WWD_RC_OFS, 16'h0000);
      // Window mode: early clear resets, late clear restarts
      reg_wr(WWD_CFG_OFS, 16'h0060);
      core_u.issue(EV_CSW);
      r = rnd();
      repeat (6 + int'(r[3:0])) @(posedge ref_clk);
      core_u.issue(EV_CLR);
      wait_evt(0, 0, 3, "early_clr");
      reg_rd(WWD_RC_OFS, 16'h0010, "early_flag");
      reg_wr(WWD_RC_OFS, 16'h0000);
      core_u.issue(EV_CSW);
      repeat (23 + int'(r[5:4])) @(posedge ref_clk);
      core_u.issue(EV_CLR);
      no_evt(0, 3, "late_clr");
      wait_evt(0, 26, 32, "late_restart");
      // Sleep on the RC source it forces, Idle with the secondary source
      reg_wr(WWD_RC_OFS, 16'h0000);
      reg_wr(WWD_CFG_OFS, 16'h01e0);
      core_u.issue(EV_CSW);
      #1;
      check("sec_run", {15'h0000, secondary_oscillator_enable}, 16'h0001);
      c = rst_seen;
      core_u.issue(EV_SLP);
      #1;
      check("in_sleep", {15'h0000, in_sleep}, 16'h0001);
      // Source enables are registered one cycle behind the state
      @(posedge ref_clk);
      #1;
      check("rc_sleep", {15'h0000, low_power_rc_clock_enable}, 16'h0001);
      check("sec_sleep", {15'h0000, secondary_oscillator_enable}, 16'h0000);
      wait_evt(1, 28, 35, "sleep_wake");
      check("no_rst_sleep", 16'(rst_seen - c), 16'h0000);
      check("left_sleep", {15'h0000, in_sleep}, 16'h0000);
      reg_rd(WWD_RC_OFS, 16'h0018, "sleep_bits");
      reg_wr(WWD_RC_OFS, 16'h0000);
      reg_rd(WWD_RC_OFS, 16'h0000, "sleep_sw_clear");
      core_u.issue(EV_IDL);
      #1;
      check("in_idle", {15'h0000, in_idle}, 16'h0001);
      wait_evt(1, 28, 35, "idle_wake");
      reg_rd(WWD_RC_OFS, 16'h0014, "idle_bits");
      reg_wr(WWD_RC_OFS, 16'h0000);
      // System timer source
      reg_wr(WWD_CFG_OFS, 16'h02e0);
      core_u.issue(EV_CSW);
      #1;
      check("syst_run", {15'h0000, systimer_enable}, 16'h0001);
      check("rc_off", {15'h0000, low_power_rc_clock_enable}, 16'h0000);
      wait_evt(0, 29, 35, "syst_timeout");
      // Enable modes
      reg_wr(WWD_CFG_OFS, 16'h0080);
      core_u.issue(EV_CSW);
      no_evt(0, 80, "mode_off");
      reg_wr(WWD_CFG_OFS, 16'h00c0);
      no_evt(0, 80, "soft_disabled");
      reg_wr(WWD_RC_OFS, 16'h0020);
      core_u.issue(EV_CSW);
      wait_evt(0, 29, 35, "soft_enabled");
      reg_rd(WWD_RC_OFS, 16'h0010, "soft_flag");
      reg_wr(WWD_RC_OFS, 16'h0020);
      reg_rd(WWD_RC_OFS, 16'h0020, "swen_set");
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      arst_n <= 1'b1;
      reg_rd(WWD_RC_OFS, 16'h0000, "swen_reset");
      reg_rd(WWD_CFG_OFS, WWD_CFG_RESET, "cfg_reset2");
      reg_wr(WWD_CFG_OFS, 16'h00a0);
      core_u.issue(EV_CSW);
      wait_evt(0, 29, 35, "active_run");
      core_u.issue(EV_SLP);
      no_evt(1, 80, "active_sleep");
      core_u.issue(EV_WAKE);
      #1;
      check("wake_other", {15'h0000, in_sleep}, 16'h0000);
      wait_evt(0, 29, 35, "active_exit");
      finish_test;
   end
endmodule
